/* File: pkg/cfs_consts.svh */
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

// Register byte offsets
`define CFS_OFS_CTRL_A    4'h0
`define CFS_OFS_CTRL_B    4'h4
`define CFS_OFS_STATUS    4'h8

// Control A fields
`define CFS_A_ENABLE      0
`define CFS_A_SLAVE       1
`define CFS_A_MODE_LO     2
`define CFS_A_MODE_HI     3
`define CFS_A_BCLK_EN     4
`define CFS_A_WIDTH       5

// Control B fields
`define CFS_B_WLEN_LO     0
`define CFS_B_WLEN_HI     3
`define CFS_B_FCNT_LO     4
`define CFS_B_FCNT_HI     7
`define CFS_B_DIV_LO      8
`define CFS_B_DIV_HI      15
`define CFS_B_WIDTH       16

// Reset values
`define CFS_RST_CTRL_A    5'h00
`define CFS_RST_CTRL_B    16'h010F

// Fixed AC-link geometry: 16 slots of 16 bit clocks
`define CFS_AC_WLEN_M1    4'hF
`define CFS_AC_FCNT       4'hF
// Wrap value of the four-bit counters
`define CFS_CNT_MAX       4'hF
// Latency of the two-flop sync on frame sync input
`define CFS_SYNC_LAT      4'h2

`endif

/* File: pkg/cfs_pkg.sv */
package cfs_pkg;

  typedef enum logic [1:0] {
    CFS_MODE_MULTI = 2'h0,
    CFS_MODE_I2S   = 2'h1,
    CFS_MODE_AC16  = 2'h2,
    CFS_MODE_AC20  = 2'h3
  } cfs_mode_e;

  typedef logic [3:0] cfs_cnt_t;

endpackage

/* File: rtl/cfs_timing.sv */
// How it works
// - Word length comes from a four-bit field holding length minus one.
// - A four-bit word counter on the bit clock counts the word length.
// - Word-size field is ignored in both AC-link modes.
// - A four-bit frame counter steps each time the word counter wraps.
// - Frame length is word length times frame-count field plus one.
// - AC-link modes ignore the frame-count field; frame is 256 clocks.
// - A two-bit mode field picks multichannel, I2S, AC16 or AC20.
// - Sync-direction bit clear drives frame sync; set receives it.
// - As master a new sync starts when the frame counter wraps to zero.
// - Multichannel master sync is high for one bit-clock period.
// - AC-link master sync is high 16 clocks, low 240 clocks.
// - I2S master sync is high on even words; fifty percent duty for an odd frame-count field.
// - Clearing enable resets all link counters and stops their outputs.
// - The bit-clock generator runs and drives its pin while disabled.
//
// Local design decisions: the Wishbone slave port and the register offsets.

`timescale 1ns/1ps
`default_nettype none
`include "cfs_consts.svh"

module cfs_timing
  import cfs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        serialBitClock,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frameSyncIn,
  output logic             frameSyncOut,
  output logic             frameSyncOe,
  output logic             bitClockOut,
  output logic             bitClockOe,
  output logic             frameStart
);

  // ---------------- Register side (ref_clk) ----------------
  logic [`CFS_A_WIDTH-1:0] ctrlA_q;
  logic [`CFS_B_WIDTH-1:0] ctrlB_q;
  logic [31:0]             rdData_d;
  logic                    wbReq;
  logic [15:0]             frameTotal_q;
  logic                    tickMeta_q;
  logic                    tickSync_q;
  logic                    tickOld_q;
  logic                    actMeta_q;
  logic                    actSync_q;
  logic [7:0]              divCnt_q;
  // Link-domain flops read here by the crossing synchronisers
  logic                    linkEn_q;
  logic                    linkTick_q;

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  // Control writes; byte lanes honoured
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlA_q <= `CFS_RST_CTRL_A;
      ctrlB_q <= `CFS_RST_CTRL_B;
    end else if (wbReq && wb_we_i) begin
      if (wb_adr_i == `CFS_OFS_CTRL_A) begin
        if (wb_sel_i[0]) begin
          ctrlA_q <= wb_dat_i[`CFS_A_WIDTH-1:0];
        end
      end else if (wb_adr_i == `CFS_OFS_CTRL_B) begin
        if (wb_sel_i[0]) begin
          ctrlB_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          ctrlB_q[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  always_comb begin
    rdData_d = 32'h0000_0000;
    if (wb_adr_i == `CFS_OFS_CTRL_A) begin
      rdData_d[`CFS_A_WIDTH-1:0] = ctrlA_q;
    end else if (wb_adr_i == `CFS_OFS_CTRL_B) begin
      rdData_d[`CFS_B_WIDTH-1:0] = ctrlB_q;
    end else if (wb_adr_i == `CFS_OFS_STATUS) begin
      rdData_d[15:0] = frameTotal_q;
      rdData_d[16]   = actSync_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      wb_dat_o <= rdData_d;
    end
  end

  // Frame ticks and link activity back from the link domain
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tickMeta_q <= 1'b0;
      tickSync_q <= 1'b0;
      tickOld_q  <= 1'b0;
      actMeta_q  <= 1'b0;
      actSync_q  <= 1'b0;
    end else begin
      tickMeta_q <= linkTick_q;
      tickSync_q <= tickMeta_q;
      tickOld_q  <= tickSync_q;
      actMeta_q  <= linkEn_q;
      actSync_q  <= actMeta_q;
    end
  end

  // Frame total clears while the interface is disabled
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frameTotal_q <= 16'h0000;
    end else if (!ctrlA_q[`CFS_A_ENABLE]) begin
      frameTotal_q <= 16'h0000;
    end else if (tickSync_q != tickOld_q) begin
      frameTotal_q <= frameTotal_q + 16'h0001;
    end
  end

  // independent clock generator
  // Half period is divider+1 reference cycles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q    <= 8'h00;
      bitClockOut <= 1'b0;
      bitClockOe  <= 1'b0;
    end else begin
      bitClockOe <= ctrlA_q[`CFS_A_BCLK_EN];
      if (!ctrlA_q[`CFS_A_BCLK_EN]) begin
        divCnt_q    <= 8'h00;
        bitClockOut <= 1'b0;
      end else if (divCnt_q == ctrlB_q[`CFS_B_DIV_HI:`CFS_B_DIV_LO]) begin
        divCnt_q    <= 8'h00;
        bitClockOut <= !bitClockOut;
      end else begin
        divCnt_q <= divCnt_q + 8'h01;
      end
    end
  end

  // ---------------- Link side (serialBitClock) ----------------
  // Settings are quasi-static; each bit passes two flops
  logic [`CFS_A_WIDTH-1:0] aMeta_q;
  logic [`CFS_A_WIDTH-1:0] aSync_q;
  logic [7:0]              bMeta_q;
  logic [7:0]              bSync_q;
  logic                    fsMeta_q;
  logic                    fsSync_q;
  logic                    fsOld_q;
  cfs_cnt_t                wordCnt_q;
  cfs_cnt_t                frameCnt_q;
  cfs_mode_e               mode;
  logic                    isAc;
  logic                    isSlave;
  cfs_cnt_t                wordLast;
  cfs_cnt_t                frameLast;
  logic                    wordWrap;
  logic                    frameWrap;
  logic                    slaveAlign;
  logic                    sync_d;

  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      aMeta_q <= `CFS_RST_CTRL_A;
      aSync_q <= `CFS_RST_CTRL_A;
      bMeta_q <= 8'h0F;
      bSync_q <= 8'h0F;
    end else begin
      aMeta_q <= ctrlA_q;
      aSync_q <= aMeta_q;
      bMeta_q <= ctrlB_q[7:0];
      bSync_q <= bMeta_q;
    end
  end

  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      fsMeta_q <= 1'b0;
      fsSync_q <= 1'b0;
      fsOld_q  <= 1'b0;
      linkEn_q <= 1'b0;
    end else begin
      fsMeta_q <= frameSyncIn;
      fsSync_q <= fsMeta_q;
      fsOld_q  <= fsSync_q;
      linkEn_q <= aSync_q[`CFS_A_ENABLE];
    end
  end

  assign mode    = cfs_mode_e'(aSync_q[`CFS_A_MODE_HI:`CFS_A_MODE_LO]);
  assign isAc    = (mode == CFS_MODE_AC16) || (mode == CFS_MODE_AC20);
  assign isSlave = aSync_q[`CFS_A_SLAVE];

  assign wordLast  = isAc ? `CFS_AC_WLEN_M1
                          : bSync_q[`CFS_B_WLEN_HI:`CFS_B_WLEN_LO];
  assign frameLast = isAc ? `CFS_AC_FCNT
                          : bSync_q[`CFS_B_FCNT_HI:`CFS_B_FCNT_LO];
  assign wordWrap  = (wordCnt_q == wordLast);
  assign frameWrap = wordWrap && (frameCnt_q == frameLast);
  assign slaveAlign = isSlave && fsSync_q && !fsOld_q;

  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      wordCnt_q <= 4'h0;
    end else if (!linkEn_q) begin
      wordCnt_q <= 4'h0;
    end else if (slaveAlign) begin
      wordCnt_q <= (wordLast >= `CFS_SYNC_LAT) ? `CFS_SYNC_LAT : 4'h0;
    end else if (wordWrap) begin
      wordCnt_q <= 4'h0;
    end else begin
      wordCnt_q <= wordCnt_q + 4'h1;
    end
  end

  // frame counter steps on word wrap
  // period of frame field plus one words
  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      frameCnt_q <= 4'h0;
    end else if (!linkEn_q || slaveAlign) begin
      frameCnt_q <= 4'h0;
    end else if (frameWrap) begin
      frameCnt_q <= 4'h0;
    end else if (wordWrap) begin
      frameCnt_q <= frameCnt_q + 4'h1;
    end
  end

  // sync shape: multichannel at both counters zero, AC-link at frame counter zero, I2S on even words
  always_comb begin
    sync_d = 1'b0;
    case (mode)
      CFS_MODE_MULTI: sync_d = (frameCnt_q == 4'h0) && (wordCnt_q == 4'h0);
      CFS_MODE_I2S:   sync_d = !frameCnt_q[0];
      default:        sync_d = (frameCnt_q == 4'h0);
    endcase
  end

  // frame start marker and pin drive
  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      frameSyncOut <= 1'b0;
      frameSyncOe  <= 1'b0;
      frameStart   <= 1'b0;
      linkTick_q   <= 1'b0;
    end else begin
      frameSyncOe  <= linkEn_q && !isSlave;
      frameSyncOut <= linkEn_q && !isSlave && sync_d;
      frameStart   <= linkEn_q && (isSlave ? slaveAlign
                      : (wordCnt_q == 4'h0) && (frameCnt_q == 4'h0));
      if (linkEn_q && frameWrap) begin
        linkTick_q <= !linkTick_q;
      end
    end
  end

endmodule // cfs_timing

`default_nettype wire

/* File: sim/cfs_codec_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_codec_model (
  input wire logic       bitClk,
  input wire logic       drive,
  input wire logic [8:0] period,
  output logic           syncOut
);
  logic [8:0] cnt_q = 9'h000;
  logic       sync_q = 1'b0;
  assign syncOut = sync_q;
  always @(posedge bitClk) begin
    if (drive) begin
      cnt_q  <= (cnt_q == period - 9'h001) ? 9'h000 : cnt_q + 9'h001;
      sync_q <= (cnt_q == 9'h000);
    end else begin
      // Released line toggles so no stale level is seen
      cnt_q  <= 9'h000;
      sync_q <= ~sync_q;
    end
  end
endmodule // cfs_codec_model
`default_nettype wire

/* File: sim/cfs_timing_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cfs_timing_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic serialBitClock,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic frameSyncOut,
  input wire logic frameSyncOe,
  input wire logic bitClockOut,
  input wire logic bitClockOe,
  input wire logic frameStart
);
  logic [8:0] perCnt_q;
  logic [4:0] hiCnt_q;
  // Bit clocks since frame start, and length of the current high run
  always_ff @(posedge serialBitClock or negedge resetn) begin
    if (!resetn) begin
      perCnt_q <= 9'h000;
      hiCnt_q  <= 5'h00;
    end else begin
      perCnt_q <= (frameStart || !frameSyncOe) ? 9'h000 : perCnt_q + 9'h001;
      hiCnt_q  <= !frameSyncOut ? 5'h00 : frameStart ? 5'h01 : hiCnt_q + 5'h01;
    end
  end
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_request_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack unasked");
  bclk_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(bitClockOut) |-> bitClockOe || $past(bitClockOe))
    else $error("bit clock moved while off");
  sync_drive_a: assert property (@(posedge serialBitClock)
    disable iff (!resetn) frameSyncOut |-> frameSyncOe)
    else $error("sync high undriven");
  sync_start_a: assert property (@(posedge serialBitClock)
    disable iff (!resetn) frameStart && frameSyncOe |-> frameSyncOut)
    else $error("no sync at frame start");
  frame_len_a: assert property (@(posedge serialBitClock)
    disable iff (!resetn) perCnt_q < 9'h100) else $error("frame too long");
  sync_width_a: assert property (@(posedge serialBitClock)
    disable iff (!resetn) frameSyncOut && !frameStart |-> hiCnt_q < 5'h10)
    else $error("sync high too long");
endmodule // cfs_timing_monitor
bind cfs_timing cfs_timing_monitor mon (.ref_clk, .resetn, .serialBitClock,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .frameSyncOut, .frameSyncOe,
  .bitClockOut, .bitClockOe, .frameStart);
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [4:0] a; logic [7:0] b; int per; int hi;} cfs_row_s;
  logic        ref_clk = 1'b0;
  logic        serialBitClock = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        codecOn = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic        ack, fsOut, fsOe, bcOe, fStart, codecSync;
  logic        bcOut, prevBc;
  int          toggles;
  int          numErrors = 0;
  int          checkCount = 0;
  int          per, hi;
  cfs_row_s    rows[6] = '{'{5'h11, 8'h13, 8, 1}, '{5'h11, 8'hFF, 256, 1},
    '{5'h11, 8'h20, 3, 1}, '{5'h15, 8'h17, 16, 8},
    '{5'h19, 8'h13, 256, 16}, '{5'h1D, 8'h00, 256, 16}};

  cfs_timing uut (.ref_clk, .resetn, .serialBitClock, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frameSyncIn(fsOe ? fsOut : codecSync), .frameSyncOut(fsOut),
    .frameSyncOe(fsOe), .bitClockOut(bcOut), .bitClockOe(bcOe),
    .frameStart(fStart));
  cfs_codec_model codec (.bitClk(serialBitClock), .drive(codecOn),
    .period(9'h008), .syncOut(codecSync));

  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #6 serialBitClock = ~serialBitClock;
  end

  task automatic conclude();
    $display("Checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20) begin
      numErrors++;
      conclude();
    end
  endtask

  // Bit clocks between two frame starts and high samples of sync between
  task automatic measure();
    int n = 0;
    per = 0;
    hi = 0;
    while (fStart !== 1'b1 && n < 600) begin
      @(negedge serialBitClock);
      n++;
    end
    do begin
      hi += (fsOut === 1'b1);
      @(negedge serialBitClock);
      per++;
    end while (fStart !== 1'b1 && per < 600);
    if (per >= 600) begin
      numErrors++;
      conclude();
    end
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrlA", rd, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk("ctrlB", rd, 32'h010F);
    wb(1'b0, 4'hC, 32'h0);
    chk("unmapped", rd, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, 4'h4, {24'h000001, rows[i].b});
      wb(1'b1, 4'h0, {27'h0, rows[i].a});
      measure();
      chk("period", per, rows[i].per);
      chk("syncHigh", hi, rows[i].hi);
      wb(1'b1, 4'h0, 32'h10);
      repeat (8) @(negedge serialBitClock);
      chk("syncOe", fsOe, 1'b0);
      chk("bclkOe", bcOe, 1'b1);
      wb(1'b0, 4'h8, 32'h0);
      chk("status", rd, 32'h0);
    end
    // Divider 1: bit clock pin toggles every two reference cycles
    prevBc = bcOut;
    toggles = 0;
    repeat (40) begin
      @(posedge ref_clk);
      toggles += (bcOut !== prevBc);
      prevBc = bcOut;
    end
    chk("bclkToggles", toggles, 20);
    codecOn <= 1'b1;
    wb(1'b1, 4'h4, 32'h0113);
    wb(1'b1, 4'h0, 32'h3);
    measure();
    chk("slavePeriod", per, 8);
    chk("slaveHigh", hi, 0);
    chk("slaveOe", fsOe, 1'b0);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("rstBclkOe", bcOe, 1'b0);
    chk("rstStart", fStart, 1'b0);
    conclude();
  end
endmodule // tb
`default_nettype wire
